// file: hw/slm_pkg.sv
package slm_pkg;

    // Widths of the switch inputs and of the stream bytes.
    localparam int MODE_W = 4;
    localparam int STN_W = 5;
    localparam int BYTE_W = 8;

    // Default number of data bytes one loopback frame may carry.
    localparam int ECHO_DEPTH = 32;

    // Protocol selection values; only this range allows the echo test.
    localparam logic [3:0] MODE_MIN = 4'h1;
    localparam logic [3:0] MODE_MAX = 4'h5;
    localparam logic [3:0] MODE_ASCII_F1 = 4'h1;
    localparam logic [3:0] MODE_BIN = 4'h5;
    localparam logic [3:0] MODE_RST = 4'h0;

    // Control characters and command codes of the dedicated protocol.
    localparam logic [7:0] CH_ENQ = 8'h05;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_DLE = 8'h10;
    localparam logic [7:0] CMD_ASC = 8'h54;
    localparam logic [7:0] CMD_BIN_HI = 8'h06;
    localparam logic [7:0] CMD_BIN_LO = 8'h19;

    // Cycles the switch synchronisers settle before settings are taken.
    localparam logic [1:0] SETTLE_CYC = 2'h3;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_STN = 4'b0001,
        S_CMD0 = 4'b0010,
        S_CMD1 = 4'b0011,
        S_LEN = 4'b0100,
        S_DATA = 4'b0101,
        S_SUM = 4'b0110,
        T_HEAD = 4'b0111,
        T_STN = 4'b1000,
        T_LEN = 4'b1001,
        T_DATA = 4'b1010,
        T_ETX = 4'b1011,
        T_SUM = 4'b1100
    } slm_state_e;

    // ASCII hex digit to nibble; bit 4 flags a character that is no digit.
    function automatic logic [4:0] slm_hex2nib(input logic [7:0] c);
        logic [4:0] r;
        r = 5'h10;
        if (c >= 8'h30 && c <= 8'h39) begin
            r = {1'b0, c[3:0]};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            r = {1'b0, c[3:0] + 4'h9};
        end
        return r;
    endfunction

    // Nibble to upper case ASCII hex digit.
    function automatic logic [7:0] slm_nib2hex(input logic [3:0] n);
        logic [7:0] r;
        r = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
        return r;
    endfunction

endpackage

// file: hw/slm_strm_if.sv
`timescale 1ns/1ps
// Byte stream with valid and ready between the engine and its buffer.
interface slm_strm_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: hw/slm_buf.sv
`timescale 1ns/1ps
module slm_buf
    import slm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    slm_strm_if.snk in_s,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);

    logic v0_r, v0_nxt, v1_r, v1_nxt;
    logic [7:0] e0_r, e0_nxt, e1_r, e1_nxt;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Two entries: the head drives the output, the second absorbs a word
    // that arrives while the receiver stalls, so none is lost.
    always_comb begin
        pop = v0_r & out_ready;
        push = in_s.valid & ~v1_r;
        v0_nxt = v0_r;
        v1_nxt = v1_r;
        e0_nxt = e0_r;
        e1_nxt = e1_r;
        if (pop) begin
            e0_nxt = v1_r ? e1_r : in_s.data;
            v0_nxt = v1_r | push;
            v1_nxt = 1'b0;
        end else if (push) begin
            if (!v0_r) begin
                e0_nxt = in_s.data;
                v0_nxt = 1'b1;
            end else begin
                e1_nxt = in_s.data;
                v1_nxt = 1'b1;
            end
        end
    end

    // Registers only; ready is taken from the second entry's flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            e0_r <= 8'h00;
            e1_r <= 8'h00;
        end else begin
            v0_r <= v0_nxt;
            v1_r <= v1_nxt;
            e0_r <= e0_nxt;
            e1_r <= e1_nxt;
        end
    end

    assign in_s.ready = ~v1_r;
    assign out_valid = v0_r;
    assign out_data = e0_r;

    AST_BUF_HOLD:
    assert property (@(posedge clk) disable iff (!rst_n)
        (v0_r && !out_ready) |=> (v0_r && $stable(e0_r)))
        else $error("Stalled echo byte changed or vanished.");

endmodule

// file: hw/slm_top.sv
`timescale 1ns/1ps
// Summary of operation
// - The echo test is started by the command TT in ASCII mode or 0619 in binary mode.
// - Data bytes of an echo request are returned to the host unchanged.
// - The echo test runs only while the selected mode is one to five.
// - After restart with the controller CPU stopped, ready goes high and echo requests are taken.
// - Mode one selects ASCII encoding with message format one.
// - The station number comes from the station switch and must match the request.
// - With the sum check switch on, requests must carry and replies carry a sum check code.
// - A new mode takes effect only after a restart.
// - The mode comes from the switch or from the software mode setting, both read at restart.
module slm_top
    import slm_pkg::*;
#(
    parameter int DEPTH = ECHO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] mode_sw,
    input wire logic [4:0] station_sw,
    input wire logic sum_check_enable_switch,
    input wire logic mode_src_soft,
    input wire logic [3:0] soft_mode,
    input wire logic cpu_stopped,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic module_ready,
    output logic [3:0] active_mode,
    output logic frame_err,
    output logic echo_done
);

    localparam logic [7:0] DEPTH_B = 8'(DEPTH);

    logic rst_s1_r, rst_n;
    logic [3:0] mode_s1_r, mode_s2_r;
    logic [4:0] stn_s1_r, stn_s2_r;
    logic sum_s1_r, sum_s2_r;

    ////////////////////////////////////////////////////////////////////////
    // Reset is released through two flops so every flop leaves it together.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // Switch pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s1_r <= 4'h0;
            mode_s2_r <= 4'h0;
            stn_s1_r <= 5'h00;
            stn_s2_r <= 5'h00;
            sum_s1_r <= 1'b0;
            sum_s2_r <= 1'b0;
        end else begin
            mode_s1_r <= mode_sw;
            mode_s2_r <= mode_s1_r;
            stn_s1_r <= station_sw;
            stn_s2_r <= stn_s1_r;
            sum_s1_r <= sum_check_enable_switch;
            sum_s2_r <= sum_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings are taken once after restart; moving a switch later has no
    // effect until the next reset, which keeps a live link stable.
    logic [1:0] settle_r, settle_nxt;
    logic cfg_done_r, cfg_done_nxt;
    logic [3:0] mode_r, mode_nxt;
    logic [4:0] stn_r, stn_nxt;
    logic sumen_r, sumen_nxt;
    logic ready_r, ready_nxt;
    logic bin_r, loop_ok;

    always_comb begin
        settle_nxt = settle_r;
        cfg_done_nxt = cfg_done_r;
        mode_nxt = mode_r;
        stn_nxt = stn_r;
        sumen_nxt = sumen_r;
        if (!cfg_done_r) begin
            if (settle_r != SETTLE_CYC) begin
                settle_nxt = settle_r + 2'h1;
            end else begin
                cfg_done_nxt = 1'b1;
                mode_nxt = mode_src_soft ? soft_mode : mode_s2_r;
                stn_nxt = stn_s2_r;
                sumen_nxt = sum_s2_r;
            end
        end
        ready_nxt = ready_r | (cfg_done_r & cpu_stopped);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_r <= 2'h0;
            cfg_done_r <= 1'b0;
            mode_r <= MODE_RST;
            stn_r <= 5'h00;
            sumen_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            settle_r <= settle_nxt;
            cfg_done_r <= cfg_done_nxt;
            mode_r <= mode_nxt;
            stn_r <= stn_nxt;
            sumen_r <= sumen_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Modes one to four use ASCII framing, five uses binary.
    assign bin_r = (mode_r == MODE_BIN);
    assign loop_ok = ready_r && mode_r >= MODE_MIN && mode_r <= MODE_MAX;

    ////////////////////////////////////////////////////////////////////////
    // Frame engine: receive a request, then replay it into the buffer.
    slm_strm_if push_s ();
    slm_state_e st_r, st_nxt;
    logic half_r, half_nxt;
    logic [3:0] hold_r, hold_nxt;
    logic [7:0] len_r, len_nxt, cnt_r, cnt_nxt, sum_r, sum_nxt;
    logic err_r, err_nxt, done_r, done_nxt;
    logic [7:0] mem [DEPTH];
    logic mem_we;
    logic [4:0] hx;
    logic [7:0] val, fval, ob;
    logic val_rdy, fdone, tx_st;

    always_comb begin
        st_nxt = st_r;
        half_nxt = half_r;
        hold_nxt = hold_r;
        len_nxt = len_r;
        cnt_nxt = cnt_r;
        sum_nxt = sum_r;
        err_nxt = 1'b0;
        done_nxt = 1'b0;
        mem_we = 1'b0;
        hx = slm_hex2nib(rx_data);
        val = bin_r ? rx_data : {hold_r, hx[3:0]};
        val_rdy = bin_r | half_r;
        fval = {3'h0, stn_r};
        ob = 8'h00;
        fdone = 1'b1;
        tx_st = (st_r >= T_HEAD);
        // Numeric fields in ASCII are two hex characters, high digit first.
        if (rx_valid && !tx_st && st_r != S_IDLE && !bin_r
            && (st_r == S_STN || st_r == S_LEN || st_r == S_SUM)) begin
            if (hx[4]) begin
                st_nxt = S_IDLE;
                err_nxt = 1'b1;
                val_rdy = 1'b0;
            end else begin
                hold_nxt = hx[3:0];
                half_nxt = ~half_r;
            end
        end
        if (rx_valid && !tx_st && st_r != S_IDLE && st_r != S_SUM) begin
            sum_nxt = sum_r + rx_data;
        end
        case (st_r)
            S_IDLE: begin
                if (rx_valid && loop_ok
                    && rx_data == (bin_r ? CH_DLE : CH_ENQ)) begin
                    st_nxt = S_STN;
                    half_nxt = 1'b0;
                    sum_nxt = 8'h00;
                end
            end
            S_STN: begin
                if (rx_valid && val_rdy && !err_nxt) begin
                    // Frames for other stations are dropped silently.
                    st_nxt = (val == {3'h0, stn_r}) ? S_CMD0 : S_IDLE;
                end
            end
            S_CMD0, S_CMD1: begin
                if (rx_valid) begin
                    if (rx_data == (bin_r ? (st_r == S_CMD0 ? CMD_BIN_HI :
                        CMD_BIN_LO) : CMD_ASC)) begin
                        st_nxt = (st_r == S_CMD0) ? S_CMD1 : S_LEN;
                    end else begin
                        st_nxt = S_IDLE;
                        err_nxt = 1'b1;
                    end
                end
            end
            S_LEN: begin
                if (rx_valid && val_rdy && !err_nxt) begin
                    len_nxt = val;
                    cnt_nxt = 8'h00;
                    if (val > DEPTH_B) begin
                        st_nxt = S_IDLE;
                        err_nxt = 1'b1;
                    end else if (val == 8'h00) begin
                        st_nxt = sumen_r ? S_SUM : T_HEAD;
                    end else begin
                        st_nxt = S_DATA;
                    end
                end
            end
            S_DATA: begin
                if (rx_valid) begin
                    mem_we = 1'b1;
                    cnt_nxt = cnt_r + 8'h01;
                    if (cnt_r == len_r - 8'h01) begin
                        st_nxt = sumen_r ? S_SUM : T_HEAD;
                    end
                end
            end
            S_SUM: begin
                if (rx_valid && val_rdy && !err_nxt) begin
                    st_nxt = (val == sum_r) ? T_HEAD : S_IDLE;
                    err_nxt = (val != sum_r);
                end
            end
            default: begin
                // Reply side: byte of the current field and its end flag.
                case (st_r)
                    T_LEN: fval = len_r;
                    T_SUM: fval = sum_r;
                    default: fval = {3'h0, stn_r};
                endcase
                if (bin_r || st_r == T_HEAD || st_r == T_DATA
                    || st_r == T_ETX) begin
                    ob = fval;
                end else begin
                    ob = slm_nib2hex(half_r ? fval[3:0] : fval[7:4]);
                    fdone = half_r;
                end
                if (st_r == T_HEAD) begin
                    ob = bin_r ? CH_DLE : CH_STX;
                end else if (st_r == T_DATA) begin
                    ob = mem[cnt_r[$clog2(DEPTH)-1:0]];
                end else if (st_r == T_ETX) begin
                    ob = CH_ETX;
                end
                if (push_s.ready) begin
                    if (!fdone) begin
                        half_nxt = 1'b1;
                    end else begin
                        half_nxt = 1'b0;
                    end
                    if (st_r != T_HEAD && st_r != T_SUM) begin
                        sum_nxt = sum_r + ob;
                    end
                    if (fdone) begin
                        case (st_r)
                            T_HEAD: begin
                                st_nxt = T_STN;
                                sum_nxt = 8'h00;
                                cnt_nxt = 8'h00;
                            end
                            T_STN: st_nxt = T_LEN;
                            T_LEN: begin
                                if (len_r != 8'h00) begin
                                    st_nxt = T_DATA;
                                end else if (!bin_r) begin
                                    st_nxt = T_ETX;
                                end else begin
                                    st_nxt = sumen_r ? T_SUM : S_IDLE;
                                    done_nxt = ~sumen_r;
                                end
                            end
                            T_DATA: begin
                                cnt_nxt = cnt_r + 8'h01;
                                if (cnt_r == len_r - 8'h01) begin
                                    if (!bin_r) begin
                                        st_nxt = T_ETX;
                                    end else begin
                                        st_nxt = sumen_r ? T_SUM : S_IDLE;
                                        done_nxt = ~sumen_r;
                                    end
                                end
                            end
                            T_ETX: begin
                                st_nxt = sumen_r ? T_SUM : S_IDLE;
                                done_nxt = ~sumen_r;
                            end
                            default: begin
                                st_nxt = S_IDLE;
                                done_nxt = 1'b1;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // Registers of the engine; the echo store is written in its own block below.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            half_r <= 1'b0;
            hold_r <= 4'h0;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            sum_r <= 8'h00;
            err_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            half_r <= half_nxt;
            hold_r <= hold_nxt;
            len_r <= len_nxt;
            cnt_r <= cnt_nxt;
            sum_r <= sum_nxt;
            err_r <= err_nxt;
            done_r <= done_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[cnt_r[$clog2(DEPTH)-1:0]] <= rx_data;
        end
    end

    assign push_s.valid = tx_st;
    assign push_s.data = ob;

    // The buffer lets the host stall the reply without losing a byte.
    slm_buf u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_s(push_s),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    assign module_ready = ready_r;
    assign active_mode = mode_r;
    assign frame_err = err_r;
    assign echo_done = done_r;

    ////////////////////////////////////////////////////////////////////////
    AST_READY_STICKY:
    assert property (@(posedge clk) disable iff (!rst_n)
        ready_r |=> ready_r)
        else $error("Ready dropped without a reset.");

    AST_READY_CAUSE:
    assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ready_r) |-> $past(cpu_stopped) && $past(cfg_done_r))
        else $error("Ready rose without a stopped CPU.");

    AST_MODE_FROZEN:
    assert property (@(posedge clk) disable iff (!rst_n)
        cfg_done_r |=> $stable(mode_r) && $stable(stn_r))
        else $error("Mode changed without a restart.");

    AST_MODE_SOURCE:
    assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cfg_done_r) |-> mode_r == ($past(mode_src_soft) ?
        $past(soft_mode) : $past(mode_s2_r)))
        else $error("Mode taken from the wrong source.");

    AST_MODE_RANGE:
    assert property (@(posedge clk) disable iff (!rst_n)
        st_r != S_IDLE |-> mode_r >= MODE_MIN && mode_r <= MODE_MAX)
        else $error("Echo test active outside protocol modes.");

    AST_ASCII_F1:
    assert property (@(posedge clk) disable iff (!rst_n)
        (mode_r == MODE_ASCII_F1 && st_r == T_HEAD && push_s.ready)
        |-> ob == CH_STX)
        else $error("Mode one reply is not ASCII framed.");

    AST_STATION:
    assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == S_CMD0 && $past(st_r) == S_STN) |-> $past(val) ==
        {3'h0, stn_r})
        else $error("Frame for another station accepted.");

    AST_COMMAND:
    assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == S_LEN && $past(st_r) == S_CMD1) |-> $past(rx_data) ==
        (bin_r ? CMD_BIN_LO : CMD_ASC))
        else $error("Wrong command code accepted.");

    AST_SUM_USE:
    assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == T_SUM || st_r == S_SUM) |-> sumen_r)
        else $error("Sum check used while disabled.");

    AST_DATA_STORE:
    assert property (@(posedge clk) disable iff (!rst_n)
        (rx_valid && st_r == S_DATA) |=>
        mem[$past(cnt_r[$clog2(DEPTH)-1:0])] == $past(rx_data))
        else $error("Received byte not kept unchanged.");

endmodule

// file: sim/slm_host_model.sv
`timescale 1ns/1ps
// Host end of the link: sends request bytes and collects every reply byte.
module slm_host_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got_q[$];
    logic slow = 1'b0;
    logic [1:0] phase = 2'h0;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // A slow host takes one byte in four, so the reply buffer must fill.
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        tx_ready <= !slow || (phase == 2'h3);
        if (tx_valid && tx_ready) begin
            got_q.push_back(tx_data);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bytes go out back to back; the idle line shows the inverted last byte
    // so that a stale value is never mistaken for a fresh one.
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= b[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~b[b.size()-1];
    endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench
    import slm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] mode_sw = 4'h0;
    logic [4:0] station_sw = 5'h00;
    logic sum_check_enable_switch = 1'b0;
    logic mode_src_soft = 1'b0;
    logic [3:0] soft_mode = 4'h0;
    logic cpu_stopped = 1'b0;
    logic rx_valid, tx_valid, tx_ready, module_ready, frame_err, echo_done;
    logic [7:0] rx_data, tx_data;
    logic [3:0] active_mode;
    logic [7:0] req[$];
    logic [7:0] exp[$];
    int errors = 0;
    int checks_done = 0;
    int ne = 0;
    int nf = 0;

    always #50 clk = ~clk;

    slm_top #(.DEPTH(4)) u_dut (.clk(clk), .rst_b(rst_b), .mode_sw(mode_sw),
        .station_sw(station_sw),
        .sum_check_enable_switch(sum_check_enable_switch),
        .mode_src_soft(mode_src_soft), .soft_mode(soft_mode),
        .cpu_stopped(cpu_stopped), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .module_ready(module_ready), .active_mode(active_mode),
        .frame_err(frame_err), .echo_done(echo_done));

    slm_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    // Pulse outputs are counted here so no single cycle is missed.
    always @(posedge clk) begin
        if (echo_done === 1'b1) ne++;
        if (frame_err === 1'b1) nf++;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Restarts only between frames, never while settings are stored.
    task automatic restart(input logic [3:0] m, input logic [4:0] s,
        input logic sc, input logic src, input logic [3:0] sm,
        input logic stop);
        int k;
        @(posedge clk);
        rst_b <= 1'b0;
        mode_sw <= m;
        station_sw <= s;
        sum_check_enable_switch <= sc;
        mode_src_soft <= src;
        soft_mode <= sm;
        cpu_stopped <= stop;
        repeat (6) @(posedge clk);
        chk("ready_in_reset", 8'h00, {7'h0, module_ready});
        rst_b <= 1'b1;
        k = 0;
        while (module_ready !== 1'b1 && k < 30) begin
            @(negedge clk);
            k++;
        end
        chk("ready", {7'h0, stop}, {7'h0, module_ready});
        chk("active_mode", {4'h0, src ? sm : m}, {4'h0, active_mode});
    endtask

    // Builds a request and its expected echo; bad corrupts the sum.
    task automatic mk(input logic bin, input logic [7:0] stn,
        input logic [7:0] len, input logic sum, input logic [7:0] bad);
        logic [7:0] rs;
        logic [7:0] ts;
        rs = 8'h00;
        ts = 8'h00;
        if (bin) begin
            req = {CH_DLE, stn, CMD_BIN_HI, CMD_BIN_LO, len};
            exp = {CH_DLE, stn, len};
        end else begin
            req = {CH_ENQ, hx(stn[7:4]), hx(stn[3:0]), CMD_ASC, CMD_ASC,
                   hx(len[7:4]), hx(len[3:0])};
            exp = {CH_STX, hx(stn[7:4]), hx(stn[3:0]),
                   hx(len[7:4]), hx(len[3:0])};
        end
        for (int i = 0; i < len; i++) begin
            req.push_back(8'h5A + 8'(i));
            exp.push_back(8'h5A + 8'(i));
        end
        if (!bin) exp.push_back(CH_ETX);
        for (int i = 1; i < req.size(); i++) rs += req[i];
        for (int i = 1; i < exp.size(); i++) ts += exp[i];
        rs ^= bad;
        if (sum && bin) begin
            req.push_back(rs);
            exp.push_back(ts);
        end else if (sum) begin
            req = {req, hx(rs[7:4]), hx(rs[3:0])};
            exp = {exp, hx(ts[7:4]), hx(ts[3:0])};
        end
    endtask

    // Sends the request, waits for the echo and compares it byte by byte.
    task automatic run(input logic want, input logic slow, input logic err);
        int k;
        u_host.slow = slow;
        u_host.got_q = {};
        ne = 0;
        nf = 0;
        u_host.send(req);
        k = 0;
        while (u_host.got_q.size() < (want ? exp.size() : 1) && k < 100) begin
            @(negedge clk);
            k++;
        end
        repeat (4) @(negedge clk);
        chk("reply_len", want ? 8'(exp.size()) : 8'h00,
            8'(u_host.got_q.size()));
        if (want && u_host.got_q.size() == exp.size()) begin
            foreach (exp[i]) chk("reply_byte", exp[i], u_host.got_q[i]);
        end
        chk("echo_done", {7'h0, want}, 8'(ne));
        chk("frame_err", {7'h0, err}, 8'(nf));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        restart(4'h5, 5'h03, 1'b0, 1'b0, 4'h0, 1'b1);
        mk(1'b1, 8'h03, 8'h01, 1'b0, 8'h00);
        run(1'b1, 1'b0, 1'b0);
        // Switch moves are driven on the rising edge like every other input.
        @(posedge clk);
        mode_sw <= 4'h1;
        mk(1'b1, 8'h03, 8'h04, 1'b0, 8'h00);
        run(1'b1, 1'b1, 1'b0);
        chk("active_mode_kept", 8'h05, {4'h0, active_mode});
        mk(1'b1, 8'h04, 8'h01, 1'b0, 8'h00);
        run(1'b0, 1'b0, 1'b0);
        mk(1'b1, 8'h03, 8'h05, 1'b0, 8'h00);
        run(1'b0, 1'b0, 1'b1);
        restart(4'h1, 5'h00, 1'b1, 1'b0, 4'h0, 1'b1);
        mk(1'b0, 8'h00, 8'h03, 1'b1, 8'h00);
        run(1'b1, 1'b1, 1'b0);
        mk(1'b0, 8'h00, 8'h02, 1'b1, 8'h01);
        run(1'b0, 1'b0, 1'b1);
        for (int m = 2; m < 5; m++) begin
            restart(4'(m), 5'h1F, 1'b0, 1'b0, 4'h0, 1'b1);
            mk(1'b0, 8'h1F, 8'h01, 1'b0, 8'h00);
            run(1'b1, 1'b0, 1'b0);
        end
        // A wrong first command character must drop the frame with an error.
        mk(1'b0, 8'h1F, 8'h01, 1'b0, 8'h00);
        req[3] = 8'h55;
        run(1'b0, 1'b0, 1'b1);
        restart(4'h0, 5'h00, 1'b1, 1'b1, 4'h5, 1'b1);
        mk(1'b1, 8'h00, 8'h02, 1'b1, 8'h00);
        run(1'b1, 1'b0, 1'b0);
        restart(4'h0, 5'h00, 1'b0, 1'b0, 4'h0, 1'b1);
        mk(1'b1, 8'h00, 8'h01, 1'b0, 8'h00);
        run(1'b0, 1'b0, 1'b0);
        restart(4'h6, 5'h00, 1'b0, 1'b0, 4'h0, 1'b1);
        run(1'b0, 1'b0, 1'b0);
        restart(4'h5, 5'h00, 1'b0, 1'b0, 4'h0, 1'b0);
        @(posedge clk);
        cpu_stopped <= 1'b1;
        repeat (3) @(negedge clk);
        chk("ready_late", 8'h01, {7'h0, module_ready});
        conclude();
    end

    // The whole sequence needs well under a tenth of this span.
    initial begin
        #2_000_000;
        errors++;
        conclude();
    end
endmodule
